// ---- verilog/scp_consts.vh ----
// constants of the serial control port
`ifndef SCP_CONSTS_VH
`define SCP_CONSTS_VH
`define SCP_DEV_ADDR 7'h1a
`define SCP_CMD_WRITE 8'h10
`define SCP_CMD_READ 8'h20
`define SCP_REG_RESET 7'h00
`define SCP_REG_ENABLE 7'h07
`define SCP_ENABLE_BIT 8
`define SCP_ENABLE_RESET 1'b0
`define SCP_BYTE_LAST 4'h8
`define SCP_ACK_LAST 4'h9
`define SCP_SPI_CMD_LAST 5'h07
`define SCP_SPI_ADDR_LAST 5'h0f
`define SCP_SPI_WORD_LAST 5'h17
`define SCP_SPI_PAIR_START 5'h08
`define SCP_OUT_MSB 4'hf
`endif

// ---- verilog/scp_sync4.v ----
// two-flop synchroniser for the four serial pins
`timescale 1ns/10ps
module scp_sync4 (
    input wire clock, // system clock
    input wire rst_n, // async reset, active low
    input wire [3:0] async_in, // pins from outside the clock domain
    output wire [3:0] sync_out // synchronised copies
);
    reg [3:0] meta_reg;
    reg [3:0] sync_reg;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 4'hf;
            sync_reg <= 4'hf;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end
    assign sync_out = sync_reg;
endmodule // scp_sync4

// ---- verilog/scp_bus_events.v ----
// edge, start and stop detection on synchronised serial lines
`timescale 1ns/10ps
module scp_bus_events (
    input wire clock, // system clock
    input wire rst_n, // async reset, active low
    input wire scl, // synchronised serial clock
    input wire sda, // synchronised serial data
    input wire csn, // synchronised chip select, active low
    output wire scl_rise, // serial clock rose
    output wire scl_fall, // serial clock fell
    output wire start_seen, // data fell while clock high
    output wire stop_seen, // data rose while clock high
    output wire csn_rise // chip select released
);
    reg scl_d_reg;
    reg sda_d_reg;
    reg csn_d_reg;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            csn_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl;
            sda_d_reg <= sda;
            csn_d_reg <= csn;
        end
    end
    assign scl_rise = scl & ~scl_d_reg;
    assign scl_fall = ~scl & scl_d_reg;
    assign start_seen = scl & scl_d_reg & sda_d_reg & ~sda;
    assign stop_seen = scl & scl_d_reg & ~sda_d_reg & sda;
    assign csn_rise = csn & ~csn_d_reg;
endmodule // scp_bus_events

// ---- verilog/scp_serial_control_port.v ----
// serial control port: two-wire, three-wire and four-wire register access
`timescale 1ns/10ps
`include "scp_consts.vh"
// Behaviour
// - mode pin and four-wire enable bit pick two-wire, three-wire or four-wire protocol
// - two-wire side is slave only, never drives clock or starts transfers
// - start condition (data falls, clock high) restarts byte framing
// - stop condition (data rises, clock high) returns to idle
// - transmitter releases data after eight bits, receiver pulls low on ninth
// - first byte holds seven address bits and a read/write bit
// - acknowledge only when received address equals 0011010
// - read sends nine bits as two bytes, high byte first, upper bits zero
// - master acknowledges each read byte; device increments address and continues
// - read address wraps from 0x7f to 0x00 until stop
// - mode pin high: write-only sixteen-bit word, address then nine data bits
// - three-wire: shift on rising clock, write last sixteen bits on chip select rise
// - four-wire only when mode pin low and enable bit set
// - fully static, no minimum serial clock rate
// - four-wire write: command 0x10, then address and nine data bits
// - four-wire read: command 0x20, padded address, two bytes on read pin
// - four-wire transfers auto-increment while selected, wrapping 0x7f to 0x00
module scp_serial_control_port (
    input wire clock, // 100 MHz system clock
    input wire rst_n, // async reset, active low
    input wire mode_pin, // high selects three-wire write-only
    input wire sclk, // serial clock from host
    input wire sdio_in, // serial data line level
    output wire sdio_out, // serial data drive value
    output wire sdio_oe, // high while pulling serial data low
    input wire chip_select_n, // chip select, active low
    output wire read_data_out_pin, // four-wire read data
    output wire read_data_out_oe, // high while read data is driven
    output wire four_wire_serial_enable, // four-wire enable bit
    output wire reg_we, // one-cycle register write strobe
    output wire [6:0] reg_waddr, // register write address
    output wire [8:0] reg_wdata, // register write data
    output wire [6:0] reg_raddr, // register read address
    input wire [8:0] reg_rdata // register read data, same clock
);
    localparam [5:0] S_IDLE = 6'b000001;
    localparam [5:0] S_RECV = 6'b000010;
    localparam [5:0] S_ACK = 6'b000100;
    localparam [5:0] S_SEND = 6'b001000;
    localparam [5:0] S_MACK = 6'b010000;
    localparam [5:0] S_SKIP = 6'b100000;

    wire [3:0] pins_s;
    wire scl_s;
    wire sda_s;
    wire csn_s;
    wire mode_s;
    wire scl_rise;
    wire scl_fall;
    wire start_seen;
    wire stop_seen;
    wire csn_rise;

    scp_sync4 u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in({mode_pin, chip_select_n, sdio_in, sclk}),
        .sync_out(pins_s)
    );
    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];
    assign csn_s = pins_s[2];
    assign mode_s = pins_s[3];

    scp_bus_events u_events (
        .clock(clock),
        .rst_n(rst_n),
        .scl(scl_s),
        .sda(sda_s),
        .csn(csn_s),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_seen(start_seen),
        .stop_seen(stop_seen),
        .csn_rise(csn_rise)
    );

    reg enable_reg;
    wire two_wire_mode = ~mode_s & ~enable_reg;
    wire three_wire_mode = mode_s;
    wire four_wire_mode = ~mode_s & enable_reg;

    // two-wire slave; only ever pulls data low, never touches the clock
    reg [5:0] state_reg;
    reg [3:0] bit_cnt_reg;
    reg [1:0] byte_idx_reg;
    reg [7:0] rx_reg;
    reg [7:0] tx_reg;
    reg rw_reg;
    reg high_half_reg;
    reg d8_reg;
    reg [6:0] i2c_idx_reg;
    reg pull_low_reg;
    wire [7:0] rx_next = {rx_reg[6:0], sda_s};
    wire i2c_wr = two_wire_mode & (state_reg == S_RECV) & scl_fall &
                  (bit_cnt_reg == `SCP_BYTE_LAST) & (byte_idx_reg == 2'h2);

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= S_IDLE;
            bit_cnt_reg <= 4'h0;
            byte_idx_reg <= 2'h0;
            rx_reg <= 8'h00;
            tx_reg <= 8'h00;
            rw_reg <= 1'b0;
            high_half_reg <= 1'b1;
            d8_reg <= 1'b0;
            i2c_idx_reg <= 7'h00;
            pull_low_reg <= 1'b0;
        end else if (!two_wire_mode || stop_seen) begin
            state_reg <= S_IDLE;
            pull_low_reg <= 1'b0;
        end else if (start_seen) begin
            state_reg <= S_RECV;
            bit_cnt_reg <= 4'h0;
            byte_idx_reg <= 2'h0;
            pull_low_reg <= 1'b0;
        end else begin
            case (state_reg)
                S_RECV: begin
                    if (scl_rise) begin
                        rx_reg <= rx_next;
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == `SCP_BYTE_LAST) begin
                        if (byte_idx_reg == 2'h0 && rx_reg[7:1] != `SCP_DEV_ADDR) begin
                            state_reg <= S_SKIP;
                        end else begin
                            state_reg <= S_ACK;
                            pull_low_reg <= 1'b1;
                        end
                        if (byte_idx_reg == 2'h0) begin
                            rw_reg <= rx_reg[0];
                            high_half_reg <= 1'b1;
                        end
                        if (byte_idx_reg == 2'h1) begin
                            i2c_idx_reg <= rx_reg[7:1];
                            d8_reg <= rx_reg[0];
                        end
                        byte_idx_reg <= (byte_idx_reg == 2'h2) ? 2'h1 : byte_idx_reg + 2'h1;
                    end
                end
                S_ACK: begin
                    if (scl_rise) begin
                        bit_cnt_reg <= `SCP_ACK_LAST;
                    end else if (scl_fall && bit_cnt_reg == `SCP_ACK_LAST) begin
                        bit_cnt_reg <= 4'h0;
                        if (rw_reg) begin
                            state_reg <= S_SEND;
                            tx_reg <= {7'h00, reg_rdata[8]};
                            pull_low_reg <= 1'b1; // first bit out is a padding zero
                        end else begin
                            state_reg <= S_RECV;
                            pull_low_reg <= 1'b0;
                        end
                    end
                end
                S_SEND: begin
                    if (scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_reg == `SCP_BYTE_LAST) begin
                            state_reg <= S_MACK;
                            pull_low_reg <= 1'b0;
                        end else begin
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            pull_low_reg <= ~tx_reg[6];
                        end
                    end
                end
                S_MACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            state_reg <= S_SKIP; // master ended the read
                        end
                        bit_cnt_reg <= `SCP_ACK_LAST;
                    end else if (scl_fall && bit_cnt_reg == `SCP_ACK_LAST) begin
                        state_reg <= S_SEND;
                        bit_cnt_reg <= 4'h0;
                        high_half_reg <= ~high_half_reg;
                        if (high_half_reg) begin
                            tx_reg <= reg_rdata[7:0];
                            pull_low_reg <= ~reg_rdata[7];
                        end else begin
                            tx_reg <= {7'h00, reg_rdata[8]};
                            pull_low_reg <= 1'b1;
                        end
                    end else if (scl_rise == 1'b0 && scl_fall == 1'b0 && bit_cnt_reg == `SCP_BYTE_LAST &&
                                 !high_half_reg) begin
                        // low byte done: advance before the next high byte is loaded
                        i2c_idx_reg <= i2c_idx_reg + 7'h01;
                        bit_cnt_reg <= `SCP_BYTE_LAST - 4'h1;
                    end
                end
                S_SKIP: begin
                    pull_low_reg <= 1'b0;
                end
                default: begin
                    state_reg <= S_IDLE;
                    pull_low_reg <= 1'b0;
                end
            endcase
        end
    end
    assign sdio_out = 1'b0;
    assign sdio_oe = pull_low_reg;

    // three-wire and four-wire shift path
    reg [15:0] shift_reg;
    reg [4:0] spi_cnt_reg;
    reg [7:0] cmd_reg;
    reg first_pair_reg;
    reg reading_reg;
    reg [3:0] out_pos_reg;
    reg [6:0] spi_idx_reg;
    reg out_bit_reg;
    wire [15:0] shift_next = {shift_reg[14:0], sda_s};
    wire [15:0] out_word = {7'h00, reg_rdata};
    wire tw_wr = three_wire_mode & csn_rise;
    wire fw_wr = four_wire_mode & ~csn_s & scl_rise & (spi_cnt_reg == `SCP_SPI_WORD_LAST) &
                 (cmd_reg == `SCP_CMD_WRITE) & ~reading_reg;
    wire [6:0] fw_addr = first_pair_reg ? shift_next[15:9] : spi_idx_reg;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= 16'h0000;
            spi_cnt_reg <= 5'h00;
            cmd_reg <= 8'h00;
            first_pair_reg <= 1'b1;
            reading_reg <= 1'b0;
            out_pos_reg <= `SCP_OUT_MSB;
            spi_idx_reg <= 7'h00;
            out_bit_reg <= 1'b0;
        end else begin
            if (three_wire_mode && scl_rise) begin
                shift_reg <= shift_next;
            end
            if (!four_wire_mode || csn_s) begin
                spi_cnt_reg <= 5'h00;
                first_pair_reg <= 1'b1;
                reading_reg <= 1'b0;
                out_bit_reg <= 1'b0;
            end else if (reading_reg) begin
                if (scl_fall) begin
                    out_bit_reg <= out_word[out_pos_reg];
                    out_pos_reg <= out_pos_reg - 4'h1;
                    if (out_pos_reg == 4'h0) begin
                        spi_idx_reg <= spi_idx_reg + 7'h01;
                    end
                end
            end else if (scl_rise) begin
                shift_reg <= shift_next;
                spi_cnt_reg <= spi_cnt_reg + 5'h01;
                if (spi_cnt_reg == `SCP_SPI_CMD_LAST) begin
                    cmd_reg <= shift_next[7:0];
                end
                if (spi_cnt_reg == `SCP_SPI_ADDR_LAST && cmd_reg == `SCP_CMD_READ) begin
                    spi_idx_reg <= shift_next[7:1];
                    reading_reg <= 1'b1;
                    out_pos_reg <= `SCP_OUT_MSB;
                end
                if (fw_wr) begin
                    spi_idx_reg <= fw_addr + 7'h01;
                    first_pair_reg <= 1'b0;
                    spi_cnt_reg <= `SCP_SPI_PAIR_START;
                end
            end
        end
    end
    assign read_data_out_pin = out_bit_reg;
    assign read_data_out_oe = reading_reg;

    // register port and the four-wire enable shadow
    reg we_reg;
    reg [6:0] waddr_reg;
    reg [8:0] wdata_reg;
    reg [6:0] raddr_reg;
    wire any_wr = i2c_wr | tw_wr | fw_wr;
    reg [6:0] wr_addr;
    reg [8:0] wr_data;
    always @* begin
        wr_addr = fw_addr;
        wr_data = shift_next[8:0];
        if (i2c_wr) begin
            wr_addr = i2c_idx_reg;
            wr_data = {d8_reg, rx_reg};
        end else if (tw_wr) begin
            wr_addr = shift_reg[15:9];
            wr_data = shift_reg[8:0];
        end
    end
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            enable_reg <= `SCP_ENABLE_RESET;
            we_reg <= 1'b0;
            waddr_reg <= 7'h00;
            wdata_reg <= 9'h000;
            raddr_reg <= 7'h00;
        end else begin
            we_reg <= any_wr;
            if (any_wr) begin
                waddr_reg <= wr_addr;
                wdata_reg <= wr_data;
                if (wr_addr == `SCP_REG_ENABLE) begin
                    enable_reg <= wr_data[`SCP_ENABLE_BIT];
                end else if (wr_addr == `SCP_REG_RESET) begin
                    enable_reg <= `SCP_ENABLE_RESET;
                end
            end
            raddr_reg <= four_wire_mode ? spi_idx_reg : i2c_idx_reg;
        end
    end
    assign four_wire_serial_enable = enable_reg;
    assign reg_we = we_reg;
    assign reg_waddr = waddr_reg;
    assign reg_wdata = wdata_reg;
    assign reg_raddr = raddr_reg;
endmodule // scp_serial_control_port

// ---- testbench/scp_serial_control_port_sva.sv ----
// assertions on the ports of the serial control port
`timescale 1ns/10ps
module scp_serial_control_port_sva (
    input wire clock, // system clock
    input wire rst_n, // async reset, active low
    input wire mode_pin, // three-wire select
    input wire sclk, // serial clock
    input wire sdio_in, // data line level
    input wire sdio_out, // data drive value
    input wire sdio_oe, // data pull enable
    input wire chip_select_n, // chip select, active low
    input wire read_data_out_pin, // four-wire read data
    input wire read_data_out_oe, // read data enable
    input wire four_wire_serial_enable, // enable bit
    input wire reg_we, // write strobe
    input wire [6:0] reg_waddr, // write address
    input wire [8:0] reg_wdata, // write data
    input wire [6:0] reg_raddr, // read address
    input wire [8:0] reg_rdata // read data
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_drive_zero; sdio_out == 1'b0; endproperty
    a_drive_zero: assert property (p_drive_zero) else $error("data drive value high");
    property p_oe_on_low; $changed(sdio_oe) |-> !$past(sclk, 2); endproperty
    a_oe_on_low: assert property (p_oe_on_low) else $error("data pull moved with clock high");
    property p_three_quiet; mode_pin [*7] |-> !sdio_oe && !read_data_out_oe; endproperty
    a_three_quiet: assert property (p_three_quiet) else $error("output driven in three-wire mode");
    property p_rd_enable; !four_wire_serial_enable [*3] |-> !read_data_out_oe; endproperty
    a_rd_enable: assert property (p_rd_enable) else $error("read pin driven while disabled");
    property p_rd_select; chip_select_n [*7] |-> !read_data_out_oe; endproperty
    a_rd_select: assert property (p_rd_select) else $error("read pin driven while deselected");
    property p_we_pulse; reg_we |=> !reg_we; endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write strobe longer than one cycle");
    property p_en_set; reg_we && reg_waddr == 7'h07 && reg_wdata[8] |-> ##[1:2] four_wire_serial_enable; endproperty
    a_en_set: assert property (p_en_set) else $error("enable bit not set by write");
    property p_en_cause; $changed(four_wire_serial_enable) |-> reg_we; endproperty
    a_en_cause: assert property (p_en_cause) else $error("enable bit moved without a write");
    c_write: cover property (reg_we);
    c_ack: cover property ($rose(sdio_oe));
    c_read4: cover property ($rose(read_data_out_oe));
endmodule // scp_serial_control_port_sva

bind scp_serial_control_port scp_serial_control_port_sva i_scp_serial_control_port_sva (
    .clock(clock), .rst_n(rst_n), .mode_pin(mode_pin), .sclk(sclk), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .chip_select_n(chip_select_n),
    .read_data_out_pin(read_data_out_pin), .read_data_out_oe(read_data_out_oe),
    .four_wire_serial_enable(four_wire_serial_enable), .reg_we(reg_we), .reg_waddr(reg_waddr),
    .reg_wdata(reg_wdata), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata)
);

// ---- testbench/scp_host_model.sv ----
// host model driving the serial control bus
`timescale 1ns/10ps
module scp_host_model (
    output logic sclk, // serial clock
    output logic pull, // host pulls data line low
    output logic csn, // chip select, active low
    input wire sda, // data line level
    input wire rd // four-wire read data line
);
    initial begin
        sclk = 1'b1;
        pull = 1'b0;
        csn = 1'b1;
    end
    task automatic start(); // data falls while clock high
        pull = 1'b0;
        #40 sclk = 1'b1;
        #40 pull = 1'b1;
        #40 sclk = 1'b0;
        #20;
    endtask
    task automatic stop(); // data rises while clock high
        pull = 1'b1;
        #40 sclk = 1'b1;
        #40 pull = 1'b0;
        #40;
    endtask
    // byte out, then release for the acknowledge
    task automatic put(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            pull = ~b[i];
            #20 sclk = 1'b1;
            #40 sclk = 1'b0;
            #20;
        end
        pull = 1'b0;
        #20 sclk = 1'b1;
        #20 ack = ~sda;
        #20 sclk = 1'b0;
        #20;
    endtask
    // byte in; long low phase lets the slave data settle
    task automatic get(output logic [7:0] b, input logic ack);
        pull = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #60 sclk = 1'b1;
            #20 b[i] = sda;
            #20 sclk = 1'b0;
        end
        #20 pull = ack;
        #20 sclk = 1'b1;
        #40 sclk = 1'b0;
        #20 pull = 1'b0;
    endtask
    // framed shift, clock still outside frames
    task automatic spi(input logic [47:0] w, input int n, output logic [47:0] r);
        r = 48'h0;
        sclk = 1'b0;
        #40 csn = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            pull = ~w[i];
            #20 sclk = 1'b1;
            #20 r = {r[46:0], rd};
            #20 sclk = 1'b0;
            #20;
        end
        #40 csn = 1'b1;
        pull = 1'b0;
        #40;
    endtask
endmodule // scp_host_model

// ---- testbench/scp_serial_control_port_tb.sv ----
// self-checking testbench of the serial control port
`timescale 1ns/10ps
module scp_serial_control_port_tb;
    logic clock, rst_n, mode_pin;
    wire sclk, host_pull, csn, sdio_out, sdio_oe, rd_pin, rd_oe, en, reg_we;
    wire [6:0] reg_waddr, reg_raddr;
    wire [8:0] reg_wdata, reg_rdata;
    wire sda = (sdio_oe ? sdio_out : 1'b1) & ~host_pull;
    wire rd_line = rd_oe ? rd_pin : 1'b0;
    logic [8:0] mem [0:127];
    logic [15:0] wq[$];
    logic [31:0] seed = 32'hf8da60b6;
    int errors = 0;
    int n_tests = 0;
    assign reg_rdata = mem[reg_raddr];
    scp_serial_control_port i_scp_serial_control_port (.clock(clock), .rst_n(rst_n), .mode_pin(mode_pin),
        .sclk(sclk), .sdio_in(sda), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .chip_select_n(csn),
        .read_data_out_pin(rd_pin), .read_data_out_oe(rd_oe), .four_wire_serial_enable(en), .reg_we(reg_we),
        .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata));
    scp_host_model i_scp_host_model (.sclk(sclk), .pull(host_pull), .csn(csn), .sda(sda), .rd(rd_line));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (reg_we) begin
            wq.push_back({reg_waddr, reg_wdata});
            mem[reg_waddr] <= reg_wdata;
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // read stream from 0x7f: high byte then low byte, then wrapped register 0
    function automatic logic [7:0] exp_byte(input int j);
        logic [8:0] v;
        v = (j < 2) ? mem[127] : mem[0];
        return j[0] ? v[7:0] : {7'h00, v[8]};
    endfunction
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wchk(input logic [6:0] a, input logic [8:0] d);
        int k;
        k = 0;
        while (wq.size() == 0 && k < 50) begin
            #10;
            k++;
        end
        if (wq.size() == 0) begin
            errors++;
            stop_test();
        end else
            chk(48'(wq.pop_front()), 48'({a, d}));
    endtask
    task automatic wr2(input logic [6:0] a, input logic [8:0] d);
        logic k;
        i_scp_host_model.start();
        i_scp_host_model.put(8'h34, k);
        chk(48'(k), 48'h1);
        i_scp_host_model.put({a, d[8]}, k);
        chk(48'(k), 48'h1);
        i_scp_host_model.put(d[7:0], k);
        chk(48'(k), 48'h1);
        i_scp_host_model.stop();
        wchk(a, d);
    endtask
    initial begin
        logic [6:0] a;
        logic [8:0] d, e;
        logic k;
        logic [7:0] b;
        logic [47:0] r;
        mode_pin = 1'b0;
        rst_n = 1'b0;
        for (int i = 0; i < 128; i++)
            mem[i] = 9'(rnd());
        repeat (4) @(posedge clock);
        #1 rst_n = 1'b1;
        #40;
        chk(48'(en), 48'h0);
        $display("test reset done");
        for (int j = 0; j < 3; j++) begin
            a = (j == 0) ? 7'h7e : 7'h08 + 7'(rnd() % 96);
            wr2(a, 9'(rnd()));
        end
        $display("test two-wire write done");
        i_scp_host_model.start();
        i_scp_host_model.put(8'h36, k);
        chk(48'(k), 48'h0);
        i_scp_host_model.put(8'h55, k);
        chk(48'(k), 48'h0);
        i_scp_host_model.stop();
        #200;
        chk(48'(wq.size()), 48'h0);
        $display("test address mismatch done");
        i_scp_host_model.start();
        i_scp_host_model.put(8'h34, k);
        i_scp_host_model.put(8'hfe, k);
        i_scp_host_model.start();
        i_scp_host_model.put(8'h35, k);
        chk(48'(k), 48'h1);
        for (int j = 0; j < 4; j++) begin
            i_scp_host_model.get(b, j < 3);
            chk(48'(b), 48'(exp_byte(j)));
        end
        i_scp_host_model.stop();
        $display("test two-wire read done");
        @(posedge clock);
        #1 mode_pin = 1'b1;
        #50;
        a = 7'h08 + 7'(rnd() % 96);
        d = 9'(rnd());
        i_scp_host_model.spi(48'({4'h5, a, d}), 20, r);
        wchk(a, d);
        i_scp_host_model.spi(48'({7'h07, 9'h100}), 16, r);
        wchk(7'h07, 9'h100);
        #30;
        chk(48'(en), 48'h1);
        $display("test three-wire done");
        @(posedge clock);
        #1 mode_pin = 1'b0;
        #50;
        i_scp_host_model.spi({8'h20, 7'h7f, 1'b0, 32'hffffffff}, 48, r);
        chk(48'(r[31:0]), 48'({7'h00, mem[127], 7'h00, mem[0]}));
        d = 9'(rnd());
        e = 9'(rnd());
        i_scp_host_model.spi(48'({8'h10, 7'h7f, d, 7'h00, e}), 40, r);
        wchk(7'h7f, d);
        wchk(7'h00, e);
        #30;
        chk(48'(en), 48'h0);
        wr2(7'h09, 9'(rnd()));
        $display("test four-wire done");
        stop_test();
    end
endmodule // scp_serial_control_port_tb
